// File: rtl/eep_cmd.sv
/*
  command logic of a two-wire serial eeprom acting as bus slave: page
  write into latches, write cycle with ecc group rewrite, id page write
  and lock, acknowledge polling and all read forms.
  assumes scl/sda arrive from the bus asynchronously; sda is open drain
  and the bench resolves the wire from sda_oe_out.
*/
// Function
// - page write takes up to 256 bytes sharing the upper address bits
// - bytes past page end wrap to offset zero in the same page
// - write protect high: data bytes get noack, memory unchanged
// - write protect low: array and unlocked id page data bytes acked, in-page counter advances
// - id page write uses type 1011b, A10 zero, low byte is offset
// - locked id page: id write data gets noack, page unchanged
// - type 1011b, A10 one, data bit 1 set locks id page forever
// - each four-byte group carries ecc, single bit corrected on read
// - writing one byte rewrites its whole four-byte group
// - during write cycle select code gets noack, afterwards acked
// - reads work whatever write protect says
// - after read byte sample ack in slot 9; none ends transfer
// - random read: write header, repeated start, read select
// - bare read select returns byte at counter, then counter increments
// - one counter shared by array and id page accesses
// - sequential read continues on master ack, wraps to 00h
// - id page read: random read with type 1011b, stay within page
// - id write header plus one byte: ack if unlocked, noack if locked
// - start resets command logic and drops unfinished instruction
// - write cycle only on stop right after a data ack slot
// - select code bit 0 picks read (1) or write (0)
// - 18-bit address: two bits from select, sixteen from address bytes
`timescale 1ns/100ps
`default_nettype none
module eep_cmd
  import eep_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DFLT
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // straps and status
  input wire logic chip_enable_in,
  input wire logic write_protect_in,
  output logic busy_out,
  output logic id_locked_out
);

  if (WR_CYCLES <= COMMIT_STEPS || WR_CYCLES >= 2 ** CNT_W) begin : g_chk
    $error("WR_CYCLES must cover the group commit and fit the counter");
  end

  // synchronisers; stage 0 feeds stage 1 only
  logic [2:0] scl_sq;
  logic [2:0] sda_sq;
  logic [1:0] wp_sq;
  logic [1:0] ce_sq;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      scl_sq <= 3'h7;
      sda_sq <= 3'h7;
      wp_sq <= 2'h0;
      ce_sq <= 2'h0;
    end else begin
      scl_sq <= {scl_sq[1:0], scl_in};
      sda_sq <= {sda_sq[1:0], sda_in};
      wp_sq <= {wp_sq[0], write_protect_in};
      ce_sq <= {ce_sq[0], chip_enable_in};
    end
  end

  wire scl_rise = scl_sq[1] & ~scl_sq[2];
  wire scl_fall = ~scl_sq[1] & scl_sq[2];
  wire scl_high = scl_sq[1] & scl_sq[2];
  wire start_det = scl_high & ~sda_sq[1] & sda_sq[2];
  wire stop_det = scl_high & sda_sq[1] & ~sda_sq[2];

  // protocol state
  eep_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic [7:0] ahi_q;
  logic [7:0] pg_q;
  logic [1:0] sel_hi_q;
  logic [ADDR_W-9:0] page_q;
  logic [ADDR_W-1:0] addr_q;
  logic mack_q;
  logic oe_q;
  logic sda_drv_q;
  logic id_q;
  logic lockc_q;
  logic lock_arm_q;
  logic stop_ok_q;
  logic [PAGE_BYTES-1:0] lat_v_q;
  logic [7:0] lat_q [0:PAGE_BYTES-1];
  // write cycle
  logic busy_q;
  logic [CNT_W-1:0] cnt_q;
  logic [6:0] cg_q;
  // nonvolatile storage, no reset by design; starts erased and unlocked
  logic locked_q = 1'b0;
  logic [ECC_W-1:0] mem_q [0:ALL_GROUPS-1] = '{default: ERASED_CODE};

  eep_ecc_if ecc_if();

  eep_ecc_codec u_ecc (
    .ecc(ecc_if.codec)
  );

  // decode
  wire [3:0] sel_type = sr_q[7:4];
  wire type_ok = (sel_type == TYPE_ARRAY) || (sel_type == TYPE_ID);
  wire sel_ok = type_ok && (sr_q[SEL_CE_POS] == ce_sq[1]) && !busy_q;
  wire wr_ok = ~wp_sq[1] & ~(id_q & locked_q);
  wire wdat_ok = wr_ok & (~lockc_q | sr_q[LOCK_BIT]);
  wire byte_end = scl_fall && (bit_q == LAST_BIT);
  wire ack_end = scl_fall && (bit_q == ACK_SLOT);
  wire data_acked = lock_arm_q | (|lat_v_q);
  wire wr_trig = stop_det && stop_ok_q && (state_q == ST_WDAT) && !busy_q;
  wire busy_end = busy_q && (cnt_q == '0);
  wire lat_we = byte_end && (state_q == ST_WDAT) && wdat_ok && !lockc_q;
  wire lat_clr = ((start_det | (stop_det & ~wr_trig)) & ~busy_q) | busy_end;

  // group addressing: id page groups sit above the array
  wire [GRP_W-1:0] rd_idx = id_q ? {1'b1, 10'h000, addr_q[7:2]}
                                 : {1'b0, addr_q[ADDR_W-1:2]};
  wire [GRP_W-1:0] cm_idx = id_q ? {1'b1, 10'h000, cg_q[5:0]}
                                 : {1'b0, page_q, cg_q[5:0]};
  wire [7:0] grp_base = {cg_q[5:0], 2'h0};
  wire grp_dirty = |lat_v_q[grp_base +: GROUP_BYTES];
  wire cm_we = busy_q && !cg_q[6] && grp_dirty;
  wire [7:0] rd_byte = ecc_if.data_fix[{addr_q[1:0], 3'h0} +: 8];
  wire [ADDR_W-1:0] addr_nx = id_q ? {addr_q[ADDR_W-1:8], addr_q[7:0] + 8'h01}
                                   : addr_q + 1'b1;

  // reads and commits never overlap: selects are refused while busy
  assign ecc_if.word_raw = mem_q[busy_q ? cm_idx : rd_idx];

  for (genvar b = 0; b < GROUP_BYTES; b++) begin : g_merge
    wire [7:0] lat_idx = grp_base | 8'(b);
    assign ecc_if.data_new[8*b +: 8] = lat_v_q[lat_idx] ? lat_q[lat_idx]
                                      : ecc_if.data_fix[8*b +: 8];
  end

  always_ff @(posedge clk_sys_in) begin
    if (lat_we) begin
      lat_q[pg_q] <= sr_q;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (cm_we) begin
      mem_q[cm_idx] <= ecc_if.code_new;
    end
    if (wr_trig && lock_arm_q) begin
      locked_q <= 1'b1;
    end
  end

  // write cycle timer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      cg_q <= '0;
    end else if (wr_trig) begin
      busy_q <= 1'b1;
      cnt_q <= CNT_W'(WR_CYCLES - 1);
      cg_q <= '0;
    end else if (busy_q) begin
      busy_q <= !busy_end;
      cnt_q <= cnt_q - 1'b1;
      if (!cg_q[6]) begin
        cg_q <= cg_q + 1'b1;
      end
    end
  end

  // bit engine and command sequencing
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      bit_q <= '0;
      sr_q <= '0;
      tx_q <= '0;
      ahi_q <= '0;
      pg_q <= '0;
      sel_hi_q <= '0;
      page_q <= '0;
      addr_q <= '0;
      mack_q <= 1'b0;
      oe_q <= 1'b0;
      sda_drv_q <= 1'b0;
      id_q <= 1'b0;
      lockc_q <= 1'b0;
      lock_arm_q <= 1'b0;
      stop_ok_q <= 1'b0;
      lat_v_q <= '0;
    end else begin
      if (start_det) begin
        state_q <= ST_SEL;
        // the scl fall that closes the start is no data bit
        bit_q <= '1;
        oe_q <= 1'b0;
        stop_ok_q <= 1'b0;
        lock_arm_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        bit_q <= '0;
        oe_q <= 1'b0;
        stop_ok_q <= 1'b0;
        lock_arm_q <= 1'b0;
        if (wr_trig) begin
          // counter points past the last byte written
          addr_q <= id_q ? {{(ADDR_W-8){1'b0}}, pg_q} : {page_q, pg_q};
        end
      end else begin
        if (scl_rise && bit_q != ACK_SLOT) begin
          sr_q <= {sr_q[6:0], sda_sq[1]};
        end
        if (scl_rise && bit_q == ACK_SLOT && state_q == ST_RDAT) begin
          mack_q <= ~sda_sq[1];
        end
        if (scl_fall) begin
          stop_ok_q <= 1'b0;
        end
        if (byte_end) begin
          bit_q <= ACK_SLOT;
          oe_q <= 1'b0;
          case (state_q)
            ST_SEL: begin
              if (sel_ok) begin
                oe_q <= 1'b1;
                id_q <= sr_q[SEL_ID_POS];
                sel_hi_q <= sr_q[2:1];
                mack_q <= 1'b1;
                state_q <= sr_q[SEL_RW_POS] ? ST_RDAT : ST_AHI;
              end else begin
                state_q <= ST_IGN;
              end
            end
            ST_AHI: begin
              oe_q <= 1'b1;
              ahi_q <= sr_q;
              state_q <= ST_ALO;
            end
            ST_ALO: begin
              oe_q <= 1'b1;
              pg_q <= sr_q;
              page_q <= {sel_hi_q, ahi_q};
              lockc_q <= id_q & ahi_q[ID_SEL_ADDR_POS];
              if (id_q) begin
                addr_q <= {{(ADDR_W-8){1'b0}}, sr_q};
              end else begin
                addr_q <= {sel_hi_q, ahi_q, sr_q};
              end
              state_q <= ST_WDAT;
            end
            ST_WDAT: begin
              // wp and lock refuse the byte
              if (wdat_ok) begin
                oe_q <= 1'b1;
                if (lockc_q) begin
                  lock_arm_q <= 1'b1;
                end else begin
                  lat_v_q[pg_q] <= 1'b1;
                  pg_q <= pg_q + 8'h01;
                end
              end
            end
            default: begin
            end
          endcase
        end else if (ack_end) begin
          bit_q <= '0;
          oe_q <= 1'b0;
          // an address ack alone must not arm the write cycle
          if (state_q == ST_WDAT && oe_q && data_acked) begin
            stop_ok_q <= 1'b1;
          end
          if (state_q == ST_RDAT) begin
            if (mack_q) begin
              tx_q <= rd_byte;
              oe_q <= ~rd_byte[7];
              addr_q <= addr_nx;
            end else begin
              state_q <= ST_IGN;
            end
          end
        end else if (scl_fall) begin
          bit_q <= bit_q + 4'h1;
          if (state_q == ST_RDAT) begin
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= ~tx_q[6];
          end
        end
      end
      if (lat_clr) begin
        lat_v_q <= '0;
      end
    end
  end

  assign sda_out = sda_drv_q;
  assign sda_oe_out = oe_q;
  assign busy_out = busy_q;
  assign id_locked_out = locked_q;

endmodule : eep_cmd
`default_nettype wire

// File: rtl/eep_ecc_codec.sv
/*
  ecc codec for one four-byte group: corrects a single bad bit of a
  stored word and encodes a new one. purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
module eep_ecc_codec
  import eep_pkg::*;
(
  eep_ecc_if.codec ecc
);

  logic [ECC_W:1] raw_w;
  logic [ECC_W:1] fix_w;
  logic [PAR_W-1:0] syn_w;
  logic [DATA_W-1:0] data_w;

  assign raw_w = ecc.word_raw;

  // single-bit correction is silent: no flag leaves the block
  always_comb begin
    int j;
    j = 0;
    syn_w = '0;
    data_w = '0;
    for (int k = 0; k < PAR_W; k++) begin
      for (int p = 1; p <= ECC_W; p++) begin
        if (((p >> k) & 1) == 1) begin
          syn_w[k] = syn_w[k] ^ raw_w[p];
        end
      end
    end
    fix_w = raw_w;
    if ((syn_w != '0) && (int'(syn_w) <= ECC_W)) begin
      fix_w[syn_w] = ~fix_w[syn_w];
    end
    for (int p = 1; p <= ECC_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        data_w[j] = fix_w[p];
        j++;
      end
    end
  end

  assign ecc.data_fix = data_w;
  assign ecc.code_new = eep_ecc_encode(ecc.data_new);

endmodule : eep_ecc_codec
`default_nettype wire

// File: rtl/eep_ecc_if.sv
/*
  carrier between the command block and its ecc codec.
  assumes the user side supplies a stored word and merged new data.
*/
`timescale 1ns/100ps
`default_nettype none
interface eep_ecc_if;
  import eep_pkg::*;
  logic [ECC_W-1:0] word_raw;
  logic [DATA_W-1:0] data_fix;
  logic [DATA_W-1:0] data_new;
  logic [ECC_W-1:0] code_new;
  modport user(output word_raw, output data_new,
               input data_fix, input code_new);
  modport codec(input word_raw, input data_new,
                output data_fix, output code_new);
endinterface : eep_ecc_if
`default_nettype wire

// File: rtl/eep_pkg.sv
/*
  shared constants, state type and ecc encoder of the two-wire eeprom
  command block. assumes a 100 MHz system clock.
*/
package eep_pkg;

  // memory organisation
  localparam int ADDR_W = 18;
  localparam int PAGE_BYTES = 256;
  localparam int GROUP_BYTES = 4;
  localparam int COMMIT_STEPS = PAGE_BYTES / GROUP_BYTES;
  localparam int ARRAY_GROUPS = 2 ** (ADDR_W - 2);
  localparam int ALL_GROUPS = ARRAY_GROUPS + COMMIT_STEPS;
  localparam int GRP_W = ADDR_W - 1;
  localparam int DATA_W = 32;
  localparam int PAR_W = 6;
  localparam int ECC_W = DATA_W + PAR_W;

  // select code and command fields
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam int SEL_CE_POS = 3;
  localparam int SEL_ID_POS = 4;
  localparam int SEL_RW_POS = 0;
  localparam int ID_SEL_ADDR_POS = 2;
  localparam int LOCK_BIT = 1;

  // bit slot counting
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLE_TIME_NS = 5000;
  localparam int WR_CYCLES_DFLT = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // delivery state of every byte
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SEL = 7'h02,
    ST_AHI = 7'h04,
    ST_ALO = 7'h08,
    ST_WDAT = 7'h10,
    ST_RDAT = 7'h20,
    ST_IGN = 7'h40
  } eep_state_t;

  // hamming code, parity at power-of-two positions 1..32
  function automatic logic [ECC_W-1:0] eep_ecc_encode(
    input logic [DATA_W-1:0] d
  );
    logic [ECC_W:1] w;
    int j;
    w = '0;
    j = 0;
    for (int p = 1; p <= ECC_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        w[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < PAR_W; k++) begin
      for (int p = 1; p <= ECC_W; p++) begin
        if ((((p >> k) & 1) == 1) && (p != (1 << k))) begin
          w[1 << k] = w[1 << k] ^ w[p];
        end
      end
    end
    return w;
  endfunction : eep_ecc_encode

  localparam logic [ECC_W-1:0] ERASED_CODE = eep_ecc_encode(ERASED_WORD);

endpackage : eep_pkg

// File: verif/eep_bus_master.sv
/*
  behavioural two-wire bus master, 16 system clocks per scl period.
  assumes the bench resolves sda from both open-drain pull-downs.
*/
`timescale 1ns/100ps
`default_nettype none
module eep_bus_master (
  // clock
  input wire logic clk_sys_in,
  // bus
  input wire logic sda_in,
  output var logic scl_out,
  output var logic sda_low_out
);
  // scl stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : w
  // sample late in the high phase, move sda only with scl low
  task automatic bit_x(input logic b, output logic r);
    sda_low_out <= !b;
    w(4);
    scl_out <= 1'b1;
    w(8);
    r = sda_in;
    scl_out <= 1'b0;
    w(4);
  endtask : bit_x
  // also serves as repeated start from mid-frame
  task automatic start();
    sda_low_out <= 1'b0;
    w(4);
    scl_out <= 1'b1;
    w(8);
    sda_low_out <= 1'b1;
    w(8);
    scl_out <= 1'b0;
    w(4);
  endtask : start
  task automatic stop();
    sda_low_out <= 1'b1;
    w(4);
    scl_out <= 1'b1;
    w(8);
    sda_low_out <= 1'b0;
    w(8);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : wbyte
  // noack on the last byte ends a read
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, b[i]);
    end
    bit_x(!mack, r);
  endtask : rbyte
endmodule : eep_bus_master
`default_nettype wire

// File: verif/eep_cmd_properties.sv
/*
  concurrent checks on the ports of the eeprom command block.
  assumes the bench moves scl and sda on system clock edges.
*/
`timescale 1ns/100ps
`default_nettype none
module eep_cmd_properties
  import eep_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DFLT
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // bus and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_out,
  input wire logic busy_out,
  input wire logic id_locked_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // length of the running write cycle so far
  int busy_cnt_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_out ? busy_cnt_q + 1 : 0;
    end
  end
  sequence busy_start;
    $rose(busy_out);
  endsequence
  // sda rose with scl high a few clocks ago: a stop
  sequence stop_seen;
    scl_in && sda_in && !$past(sda_in, 8);
  endsequence
  busy_len_a: assert property ($fell(busy_out) |-> busy_cnt_q == WR_CYCLES)
    else $error("write cycle length wrong");
  busy_max_a: assert property (busy_out |-> busy_cnt_q < WR_CYCLES)
    else $error("write cycle too long");
  busy_quiet_a: assert property (busy_out |-> !sda_oe_out)
    else $error("device drives sda while busy");
  stop_trigger_a: assert property (busy_start |-> stop_seen)
    else $error("write cycle without stop");
  lock_keep_a: assert property (!$fell(id_locked_out))
    else $error("id page lock lost");
  lock_cycle_a: assert property ($rose(id_locked_out) |-> busy_out)
    else $error("lock outside a write cycle");
  drive_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("sda drive changed with scl high");
  reset_idle_a: assert property (disable iff (1'b0)
    rst_in |=> !busy_out && !sda_oe_out)
    else $error("busy or drive after reset");
endmodule : eep_cmd_properties
bind eep_cmd eep_cmd_properties #(.WR_CYCLES(WR_CYCLES)) u_props (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_out(sda_oe_out), .busy_out(busy_out),
  .id_locked_out(id_locked_out));
`default_nettype wire

// File: verif/test_eep_cmd.sv
/*
  self-checking bench of the eeprom command block.
  assumes the bus master model and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_eep_cmd;
  import eep_pkg::*;
  // short write cycle, still longer than one select code
  localparam int WR_N = 300;
  logic clk_sys_in, rst_in, chip_enable_in, write_protect_in;
  logic sda_out, sda_oe_out, busy_out, id_locked_out, scl, m_low, k;
  wire logic sda;
  int num_errors = 0;
  int total_checks = 0;
  assign sda = !(sda_oe_out || m_low);
  eep_cmd #(.WR_CYCLES(WR_N)) dut (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .chip_enable_in(chip_enable_in),
    .write_protect_in(write_protect_in), .busy_out(busy_out),
    .id_locked_out(id_locked_out));
  eep_bus_master m (.clk_sys_in(clk_sys_in), .sda_in(sda),
    .scl_out(scl), .sda_low_out(m_low));
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic sel(input logic [3:0] ty, input logic [2:0] mid,
                     input logic rw, output logic ack);
    m.start();
    m.wbyte({ty, mid, rw}, ack);
  endtask : sel
  task automatic hdr(input logic [3:0] ty, input logic [17:0] a);
    logic k1, k2, k3;
    sel(ty, {1'b1, a[17:16]}, 1'b0, k1);
    m.wbyte(a[15:8], k2);
    m.wbyte(a[7:0], k3);
    `CHK(k1 && k2 && k3, 1'b1)
  endtask : hdr
  task automatic wr(input logic [3:0] ty, input logic [17:0] a,
                    input logic [31:0] d, input int n, input logic ea);
    logic ok;
    hdr(ty, a);
    for (int i = 0; i < n; i++) begin
      m.wbyte(d[31-8*i -: 8], ok);
      `CHK(ok, ea)
    end
    m.stop();
  endtask : wr
  task automatic cur(input logic [3:0] ty, input logic [1:0] hi,
                     input logic [31:0] e, input int n);
    logic ok;
    logic [7:0] v;
    sel(ty, {1'b1, hi}, 1'b1, ok);
    `CHK(ok, 1'b1)
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, v);
      `CHK(v, e[31-8*i -: 8])
    end
    m.stop();
  endtask : cur
  task automatic rd(input logic [3:0] ty, input logic [17:0] a,
                    input logic [31:0] e, input int n);
    hdr(ty, a);
    cur(ty, a[17:16], e, n);
  endtask : rd
  task automatic settle(input logic eb);
    int t;
    repeat (8) @(posedge clk_sys_in);
    `CHK(busy_out, eb)
    t = 0;
    while (busy_out !== 1'b0 && t < 1000) begin
      @(posedge clk_sys_in);
      t++;
    end
    `CHK(busy_out, 1'b0)
  endtask : settle
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (90000) @(posedge clk_sys_in);
    num_errors++;
    conclude();
  end
  initial begin
    rst_in = 1'b1;
    chip_enable_in = 1'b1;
    write_protect_in = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    // page write rolls over to offset zero
    wr(TYPE_ARRAY, 18'h000FE, 32'h11121314, 4, 1'b1);
    `CHK(busy_out, 1'b1)
    sel(TYPE_ARRAY, 3'h4, 1'b0, k);
    `CHK(k, 1'b0)
    for (int i = 0; i < 8 && k !== 1'b1; i++) begin
      sel(TYPE_ARRAY, 3'h4, 1'b0, k);
    end
    `CHK(k, 1'b1)
    m.stop();
    rd(TYPE_ARRAY, 18'h00000, 32'h13000000, 1);
    cur(TYPE_ARRAY, 2'h0, 32'h14000000, 1);
    rd(TYPE_ARRAY, 18'h000FE, 32'h1112FFFF, 4);
    rd(TYPE_ARRAY, 18'h3FFFF, 32'hFF130000, 2);
    // single byte in a group leaves its neighbours alone
    wr(TYPE_ARRAY, 18'h00103, 32'h5A000000, 1, 1'b1);
    settle(1'b1);
    rd(TYPE_ARRAY, 18'h00100, 32'hFFFFFF5A, 4);
    write_protect_in <= 1'b1;
    wr(TYPE_ARRAY, 18'h00000, 32'h55000000, 1, 1'b0);
    settle(1'b0);
    rd(TYPE_ARRAY, 18'h00000, 32'h13000000, 1);
    write_protect_in <= 1'b0;
    // unfinished write dropped by a start
    hdr(TYPE_ARRAY, 18'h00001);
    m.wbyte(8'h66, k);
    m.start();
    m.stop();
    settle(1'b0);
    rd(TYPE_ARRAY, 18'h00001, 32'h14000000, 1);
    // a stop right after the address bytes starts no write
    hdr(TYPE_ARRAY, 18'h00002);
    m.stop();
    settle(1'b0);
    wr(TYPE_ID, 18'h000FE, 32'hAA000000, 1, 1'b1);
    settle(1'b1);
    rd(TYPE_ID, 18'h300FE, 32'hAA000000, 1);
    cur(TYPE_ARRAY, 2'h0, 32'h12000000, 1);
    wr(TYPE_ID, 18'h00400, 32'h01000000, 1, 1'b0);
    settle(1'b0);
    `CHK(id_locked_out, 1'b0)
    wr(TYPE_ID, 18'h00400, 32'h02000000, 1, 1'b1);
    settle(1'b1);
    `CHK(id_locked_out, 1'b1)
    wr(TYPE_ID, 18'h00000, 32'h77000000, 1, 1'b0);
    settle(1'b0);
    rd(TYPE_ID, 18'h00000, 32'hFF000000, 1);
    `CHK(sda_out, 1'b0)
    conclude();
  end
endmodule : test_eep_cmd
`default_nettype wire
